// ===== rsm_params.svh
// register offsets, field positions and reset values of the relay signal routing matrix
`ifndef RSM_PARAMS_SVH
`define RSM_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RSM_OFF_ALARM2 8'h00
`define RSM_OFF_ROUTE2 8'h04
`define RSM_OFF_FSEL 8'h08
`define RSM_OFF_STAT 8'h0C
`define RSM_OFF_MASK 8'h10
`define RSM_OFF_LIVE 8'h14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RSM_RST_ALARM2 8'h00
`define RSM_RST_ROUTE2 8'h80
`define RSM_RST_FSEL 6'h00
`define RSM_RST_STAT 2'h0
`define RSM_RST_MASK 2'h0

// ----------------------------------------------------------------
// stage indication bit positions
// ----------------------------------------------------------------
`define RSM_IND_OCLS_START 0
`define RSM_IND_OCLS_TRIP 1
`define RSM_IND_OCHS_START 2
`define RSM_IND_OCHS_TRIP 3
`define RSM_IND_EFLS_START 4
`define RSM_IND_EFLS_TRIP 5
`define RSM_IND_EFHS_START 6
`define RSM_IND_EFHS_TRIP 7

// ----------------------------------------------------------------
// field positions in the function and second-output registers
// ----------------------------------------------------------------
`define RSM_ROUTE2_EFHS_TRIP 7
`define RSM_FSEL_CHAR_LSB 0
`define RSM_FSEL_CHAR_MSB 2
`define RSM_FSEL_CBFP 3
`define RSM_FSEL_DOUBLE 4
`define RSM_FSEL_EFBLK 5

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define RSM_STAT_SIG2 0
`define RSM_STAT_SIG4 1

`endif

// ===== rsm_pkg.sv
// types shared by the relay signal routing matrix
package rsm_pkg;

  // low-set overcurrent operating characteristic
  typedef enum logic [2:0] {
    RSM_CHAR_DEFINITE = 3'h0,
    RSM_CHAR_STANDARD = 3'h1,
    RSM_CHAR_VERY = 3'h2,
    RSM_CHAR_EXTREME = 3'h3,
    RSM_CHAR_LONG = 3'h4
  } rsm_char_t;

  // switch code to characteristic; unused codes fall back to definite time
  function automatic rsm_char_t rsm_char_decode(input logic [2:0] code);
    rsm_char_t c;
    c = RSM_CHAR_DEFINITE;
    if (code == 3'h1) c = RSM_CHAR_STANDARD;
    else if (code == 3'h2) c = RSM_CHAR_VERY;
    else if (code == 3'h3) c = RSM_CHAR_EXTREME;
    else if (code == 3'h4) c = RSM_CHAR_LONG;
    return c;
  endfunction

endpackage

// ===== rsm_route.sv
// or of all indications whose routing switch is closed
`timescale 1ns/10ps
module rsm_route #(
  parameter int W = 8
) (
  // indications and switches
  input wire logic [W-1:0] ind,
  input wire logic [W-1:0] sel,
  // routed result
  output logic hit
);

  logic [W-1:0] term;

  // one and-gate per switch position
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_term
      assign term[i] = ind[i] & sel[i];
    end
  endgenerate

  // any closed path drives the output
  assign hit = |term;

endmodule

// ===== rsm_matrix.sv
// relay signal routing matrix with ahb-lite register access
//
// What this block does
// - alarm switch bit 1 routes low-set overcurrent start to output two; default off.
// - alarm switch bit 2 routes low-set overcurrent trip to output two; default off.
// - alarm switch bit 3 routes high-set overcurrent start to output two; default off.
// - alarm switch bit 4 routes high-set overcurrent trip to output two; default off.
// - alarm switch bit 5 routes low-set earth-fault start to output two; default off.
// - alarm switch bit 6 routes low-set earth-fault trip to output two; default off.
// - alarm switch bit 7 routes high-set earth-fault start to output two; default off.
// - alarm switch bit 8 routes high-set earth-fault trip to output two; default off.
// - second-output switch bit 8 routes high-set earth-fault trip to output four; default on.
// - function bits 1..3 pick definite time or one of four inverse curves.
// - function bit 4 enables breaker failure protection; default off.
// - function bit 5 doubles high-set overcurrent start value during energizing.
// - function bit 6 blocks high-set earth-fault while low-set overcurrent has started.
`timescale 1ns/10ps
`include "rsm_params.svh"
module rsm_matrix (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // stage detector indications, asynchronous pins
  input wire logic [7:0] stage_ind,
  input wire logic energizing,
  // routed signal outputs
  output logic sig_two_q,
  output logic sig_four_q,
  // function selections to the stage logic
  output rsm_pkg::rsm_char_t char_sel_q,
  output logic cbfp_en_q,
  output logic hs_oc_double_q,
  output logic ef_hs_block_q,
  // interrupt
  output logic irq_q
);
  import rsm_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic [7:0] ind_s;
  logic ener_s;

  // two flops per pin; only the second stage is read by logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
    end
    else
    begin
      meta_q <= {energizing, stage_ind};
      sync_q <= meta_q;
    end
  end

  assign ind_s = sync_q[7:0];
  assign ener_s = sync_q[8];

  // ----------------------------------------------------------------
  // configuration and interrupt registers
  // ----------------------------------------------------------------
  logic [7:0] alarm_q;
  logic [7:0] alarm_d;
  logic [7:0] route2_q;
  logic [7:0] route2_d;
  logic [5:0] fsel_q;
  logic [5:0] fsel_d;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic ap_wr_q;
  logic ap_wr_d;
  logic [7:0] ap_addr_q;
  logic [7:0] ap_addr_d;
  logic [31:0] rdata_d;
  logic [1:0] stat_set;
  logic [1:0] stat_clr;
  logic ap_take;

  // an address phase is taken only when selected, non-idle and the bus is ready
  assign ap_take = hsel & htrans[1] & hready;

  // address phase capture for the following data phase
  always_comb
  begin
    ap_wr_d = ap_take & hwrite;
    ap_addr_d = ap_take ? haddr[7:0] : ap_addr_q;
  end

  // data phase writes; unmapped offsets are ignored
  always_comb
  begin
    alarm_d = alarm_q;
    route2_d = route2_q;
    fsel_d = fsel_q;
    mask_d = mask_q;
    stat_clr = 2'h0;
    if (ap_wr_q)
    begin
      if (ap_addr_q == `RSM_OFF_ALARM2)
      begin
        alarm_d = hwdata[7:0];
      end
      else if (ap_addr_q == `RSM_OFF_ROUTE2)
      begin
        route2_d = hwdata[7:0];
      end
      else if (ap_addr_q == `RSM_OFF_FSEL)
      begin
        fsel_d = hwdata[5:0];
      end
      else if (ap_addr_q == `RSM_OFF_STAT)
      begin
        stat_clr = hwdata[1:0];
      end
      else if (ap_addr_q == `RSM_OFF_MASK)
      begin
        mask_d = hwdata[1:0];
      end
    end
    // a new event beats a clear written in the same cycle
    stat_d = (stat_q & ~stat_clr) | stat_set;
  end

  // ----------------------------------------------------------------
  // routing
  // ----------------------------------------------------------------
  logic efhs_blk;
  logic [7:0] ind_g;
  logic [7:0] sel4;
  logic hit2;
  logic hit4;

  // blocked high-set earth-fault indications never reach an output
  always_comb
  begin
    efhs_blk = fsel_q[`RSM_FSEL_EFBLK] & ind_s[`RSM_IND_OCLS_START];
    ind_g = ind_s;
    if (efhs_blk)
    begin
      ind_g[`RSM_IND_EFHS_START] = 1'b0;
      ind_g[`RSM_IND_EFHS_TRIP] = 1'b0;
    end
    sel4 = 8'h00;
    sel4[`RSM_IND_EFHS_TRIP] = route2_q[`RSM_ROUTE2_EFHS_TRIP];
  end

  // output two: every alarm switch position may close
  rsm_route #(
    .W(8)
  ) u_route_two (
    .ind(ind_g),
    .sel(alarm_q),
    .hit(hit2)
  );

  // output four: only the high-set earth-fault trip path lives in this block
  rsm_route #(
    .W(8)
  ) u_route_four (
    .ind(ind_g),
    .sel(sel4),
    .hit(hit4)
  );

  // ----------------------------------------------------------------
  // outputs and events
  // ----------------------------------------------------------------
  logic sig_two_d;
  logic sig_four_d;
  rsm_char_t char_sel_d;
  logic cbfp_en_d;
  logic hs_oc_double_d;
  logic ef_hs_block_d;
  logic irq_d;

  // routed outputs, function selections and rising-edge events
  always_comb
  begin
    sig_two_d = hit2;
    sig_four_d = hit4;
    char_sel_d = rsm_char_decode(fsel_q[`RSM_FSEL_CHAR_MSB:`RSM_FSEL_CHAR_LSB]);
    cbfp_en_d = fsel_q[`RSM_FSEL_CBFP];
    hs_oc_double_d = fsel_q[`RSM_FSEL_DOUBLE] & ener_s;
    ef_hs_block_d = efhs_blk;
    stat_set = 2'h0;
    stat_set[`RSM_STAT_SIG2] = sig_two_d & ~sig_two_q;
    stat_set[`RSM_STAT_SIG4] = sig_four_d & ~sig_four_q;
    // level interrupt follows the new status so a clear drops it at once
    irq_d = |(stat_d & mask_d);
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reads use next values so a write just ahead is never seen stale
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (ap_take & ~hwrite)
    begin
      if (haddr[7:0] == `RSM_OFF_ALARM2)
      begin
        rdata_d[7:0] = alarm_d;
      end
      else if (haddr[7:0] == `RSM_OFF_ROUTE2)
      begin
        rdata_d[7:0] = route2_d;
      end
      else if (haddr[7:0] == `RSM_OFF_FSEL)
      begin
        rdata_d[5:0] = fsel_d;
      end
      else if (haddr[7:0] == `RSM_OFF_STAT)
      begin
        rdata_d[1:0] = stat_d;
      end
      else if (haddr[7:0] == `RSM_OFF_MASK)
      begin
        rdata_d[1:0] = mask_d;
      end
      else if (haddr[7:0] == `RSM_OFF_LIVE)
      begin
        rdata_d[7:0] = ind_s;
        rdata_d[8] = ener_s;
        rdata_d[9] = sig_two_d;
        rdata_d[10] = sig_four_d;
        rdata_d[11] = efhs_blk;
      end
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // switch defaults are the reset values; the bus never errors and waits only until the first edge after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_q <= `RSM_RST_ALARM2;
      route2_q <= `RSM_RST_ROUTE2;
      fsel_q <= `RSM_RST_FSEL;
      stat_q <= `RSM_RST_STAT;
      mask_q <= `RSM_RST_MASK;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      sig_two_q <= 1'b0;
      sig_four_q <= 1'b0;
      char_sel_q <= RSM_CHAR_DEFINITE;
      cbfp_en_q <= 1'b0;
      hs_oc_double_q <= 1'b0;
      ef_hs_block_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      route2_q <= route2_d;
      fsel_q <= fsel_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ap_wr_q <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      hrdata <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      sig_two_q <= sig_two_d;
      sig_four_q <= sig_four_d;
      char_sel_q <= char_sel_d;
      cbfp_en_q <= cbfp_en_d;
      hs_oc_double_q <= hs_oc_double_d;
      ef_hs_block_q <= ef_hs_block_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // an indication whose alarm switch is closed
  sequence routed_two(int b);
    alarm_q[b] && ind_g[b];
  endsequence

  // an enabled path must show on output two one edge later
  property route_two_p(int b);
    routed_two(b) |=> sig_two_q;
  endproperty

  ocls_start_a: assert property (route_two_p(0)) else $error("ls oc start not routed");
  ocls_trip_a: assert property (route_two_p(1)) else $error("ls oc trip not routed");
  ochs_start_a: assert property (route_two_p(2)) else $error("hs oc start not routed");
  ochs_trip_a: assert property (route_two_p(3)) else $error("hs oc trip not routed");
  efls_start_a: assert property (route_two_p(4)) else $error("ls ef start not routed");
  efls_trip_a: assert property (route_two_p(5)) else $error("ls ef trip not routed");
  efhs_start_a: assert property (route_two_p(6)) else $error("hs ef start not routed");
  efhs_trip_a: assert property (route_two_p(7)) else $error("hs ef trip not routed");

  // output four follows the second-output switch and the gated trip together
  four_route_a: assert property ((route2_q[7] && ind_g[7]) |=> sig_four_q)
    else $error("hs ef trip missing on output four");

  // with no closed path the outputs stay low
  two_idle_a: assert property (((alarm_q & ind_g) == 8'h00) |=> !sig_two_q)
    else $error("output two high without a routed path");
  four_idle_a: assert property (!(route2_q[7] && ind_g[7]) |=> !sig_four_q)
    else $error("output four high without a routed path");

  // characteristic output tracks the three selection bits
  char_sel_a: assert property (##1 char_sel_q == rsm_char_decode($past(fsel_q[2:0])))
    else $error("characteristic selection mismatch");

  // breaker failure enable settles one edge after the bit changes
  cbfp_en_a: assert property ($changed(fsel_q[3]) |=> cbfp_en_q == $past(fsel_q[3]))
    else $error("breaker failure enable wrong");

  // doubling only while energizing and selected, and always then
  oc_double_a: assert property ((fsel_q[4] && ener_s) |=> hs_oc_double_q ##0 $past(ener_s))
    else $error("start value doubling wrong");
  oc_nodouble_a: assert property (!(fsel_q[4] && ener_s) |=> !hs_oc_double_q)
    else $error("doubling without cause");

  // with the block bit set, a low-set overcurrent start hides both high-set earth-fault indications
  ef_block_a: assert property ((fsel_q[5] && ind_s[0]) |-> (ind_g[7:6] == 2'h0) ##1 ef_hs_block_q)
    else $error("hs earth-fault not blocked");

endmodule

// ===== rsm_stage_model.sv
// behavioural stage detectors and energizing sensor driving the matrix pins
`timescale 1ns/10ps
module rsm_stage_model (
  // clock
  input wire logic hclk,
  // levels wanted by the bench
  input wire logic [7:0] ind_req,
  input wire logic ener_req,
  // pins into the matrix
  output logic [7:0] stage_ind,
  output logic energizing
);
  // pins follow the requests one edge later, launched like a detector's own flop
  always @(posedge hclk)
  begin
    stage_ind <= ind_req;
    energizing <= ener_req;
  end
endmodule

// ===== tb_top.sv
// self-checking bench for the relay signal routing matrix
`timescale 1ns/10ps
`include "rsm_params.svh"
module tb_top;
  import rsm_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] stage_ind;
  logic energizing;
  logic [7:0] ind_req;
  logic ener_req;
  logic sig_two_q;
  logic sig_four_q;
  rsm_char_t char_sel_q;
  logic cbfp_en_q;
  logic hs_oc_double_q;
  logic ef_hs_block_q;
  logic irq_q;
  int bad_count;
  int num_checks;
  logic [31:0] rd;
  rsm_char_t char_tab [8];

  // ----
  // design, far side and clock
  // ----
  rsm_matrix i_rsm_matrix (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stage_ind(stage_ind), .energizing(energizing),
    .sig_two_q(sig_two_q), .sig_four_q(sig_four_q), .char_sel_q(char_sel_q), .cbfp_en_q(cbfp_en_q),
    .hs_oc_double_q(hs_oc_double_q), .ef_hs_block_q(ef_hs_block_q), .irq_q(irq_q));
  rsm_stage_model i_rsm_stage_model (.hclk(hclk), .ind_req(ind_req), .ener_req(ener_req),
    .stage_ind(stage_ind), .energizing(energizing));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----
  // tasks
  // ----
  task automatic end_of_test;
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      bad_count++;
    end
  endtask
  // a hung bus ends the run instead of stalling it
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1)
    begin
      $display("wrong value at %0t: bus answer timed out", $time);
      bad_count++;
      end_of_test;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= 32'(a);
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask
  // pin change plus two sync flops and the output flop fit in five edges
  task automatic settle(input logic [7:0] i, input logic e);
    ind_req <= i;
    ener_req <= e;
    repeat (5) @(posedge hclk);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ind_req = 8'h00;
    ener_req = 1'b0;
    bad_count = 0;
    num_checks = 0;
    char_tab = '{RSM_CHAR_DEFINITE, RSM_CHAR_STANDARD, RSM_CHAR_VERY, RSM_CHAR_EXTREME, RSM_CHAR_LONG,
      RSM_CHAR_DEFINITE, RSM_CHAR_DEFINITE, RSM_CHAR_DEFINITE};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // switch defaults
    rdchk(`RSM_OFF_ALARM2, 32'h0000_0000, "alarm default");
    rdchk(`RSM_OFF_ROUTE2, 32'h0000_0080, "route2 default");
    rdchk(`RSM_OFF_FSEL, 32'h0000_0000, "fsel default");
    chk(32'({cbfp_en_q, hs_oc_double_q, ef_hs_block_q}), 32'h0000_0000, "function outs");
    chk(32'(hresp), 32'h0000_0000, "hresp");
    // each alarm switch alone routes only its own indication
    for (int i = 0; i < 8; i++)
    begin
      wr(`RSM_OFF_ALARM2, 32'(8'h01 << i));
      settle(8'h01 << i, 1'b0);
      chk(32'(sig_two_q), 32'h0000_0001, "routed");
      settle(~(8'h01 << i), 1'b0);
      chk(32'(sig_two_q), 32'h0000_0000, "unrouted");
    end
    wr(`RSM_OFF_ALARM2, 32'h0000_00FF);
    settle(8'h24, 1'b0);
    chk(32'(sig_two_q), 32'h0000_0001, "or of two");
    // output four follows only its one switch
    settle(8'h80, 1'b0);
    chk(32'(sig_four_q), 32'h0000_0001, "four on");
    settle(8'h7F, 1'b0);
    chk(32'(sig_four_q), 32'h0000_0000, "four others");
    wr(`RSM_OFF_ROUTE2, 32'h0000_0000);
    settle(8'h80, 1'b0);
    chk(32'(sig_four_q), 32'h0000_0000, "four off");
    wr(`RSM_OFF_ROUTE2, 32'h0000_0080);
    // every characteristic code, plus the unused codes that fall back to definite time
    for (int c = 0; c < 8; c++)
    begin
      wr(`RSM_OFF_FSEL, 32'(c));
      settle(8'h00, 1'b0);
      chk(32'(char_sel_q), 32'(char_tab[c]), "characteristic");
    end
    wr(`RSM_OFF_FSEL, 32'h0000_0008);
    settle(8'h00, 1'b1);
    chk(32'({cbfp_en_q, hs_oc_double_q}), 32'h0000_0002, "cbfp only");
    wr(`RSM_OFF_FSEL, 32'h0000_0010);
    settle(8'h00, 1'b1);
    chk(32'(hs_oc_double_q), 32'h0000_0001, "doubling");
    settle(8'h00, 1'b0);
    chk(32'(hs_oc_double_q), 32'h0000_0000, "no energizing");
    // earth-fault high-set blocked while low-set overcurrent has started
    wr(`RSM_OFF_ALARM2, 32'h0000_0080);
    wr(`RSM_OFF_FSEL, 32'h0000_0020);
    settle(8'h81, 1'b0);
    chk(32'({ef_hs_block_q, sig_two_q, sig_four_q}), 32'h0000_0004, "blocked");
    settle(8'h80, 1'b0);
    chk(32'({ef_hs_block_q, sig_two_q, sig_four_q}), 32'h0000_0003, "released");
    // interrupt: raise, mask, clear
    wr(`RSM_OFF_MASK, 32'h0000_0001);
    settle(8'h00, 1'b0);
    wr(`RSM_OFF_STAT, 32'h0000_0003);
    rdchk(`RSM_OFF_STAT, 32'h0000_0000, "status cleared");
    chk(32'(irq_q), 32'h0000_0000, "irq idle");
    settle(8'h80, 1'b0);
    rdchk(`RSM_OFF_STAT, 32'h0000_0003, "both rose");
    chk(32'(irq_q), 32'h0000_0001, "irq up");
    wr(`RSM_OFF_MASK, 32'h0000_0000);
    settle(8'h80, 1'b0);
    chk(32'(irq_q), 32'h0000_0000, "irq masked");
    wr(`RSM_OFF_MASK, 32'h0000_0002);
    wr(`RSM_OFF_STAT, 32'h0000_0002);
    settle(8'h80, 1'b0);
    rdchk(`RSM_OFF_STAT, 32'h0000_0001, "one cleared");
    chk(32'(irq_q), 32'h0000_0000, "irq after clear");
    rdchk(`RSM_OFF_MASK, 32'h0000_0002, "mask back");
    // narrow fields, unmapped and read-only places
    wr(`RSM_OFF_ALARM2, 32'hFFFF_FF5A);
    rdchk(`RSM_OFF_ALARM2, 32'h0000_005A, "alarm width");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0000_0000, "unmapped");
    wr(`RSM_OFF_LIVE, 32'hFFFF_FFFF);
    rdchk(`RSM_OFF_LIVE, 32'h0000_0480, "live view");
    end_of_test;
  end
endmodule
